// ===== pkg/slc_pkg.sv
// shared constants and encodings for the serial link output control block
package slc_pkg;
  // lane geometry
  localparam int SLC_NLANES = 8;
  localparam int SLC_LW = 8;
  localparam int SLC_UPPER_BASE = 4;
  localparam logic [3:0] SLC_UPPER_MAX_LANES = 4'h4;
  // device register byte addresses
  localparam logic [9:0] SLC_A_ENABLE = 10'h200;
  localparam logic [9:0] SLC_A_MODE = 10'h201;
  localparam logic [9:0] SLC_A_RESYNC = 10'h203;
  localparam logic [9:0] SLC_A_CTRL = 10'h204;
  localparam logic [9:0] SLC_A_PAT = 10'h205;
  localparam logic [9:0] SLC_A_DID = 10'h206;
  localparam logic [9:0] SLC_A_AUX = 10'h2F0;
  localparam logic [9:0] SLC_A_STAT = 10'h2F1;
  // device reset values
  localparam logic [7:0] SLC_ENABLE_RST = 8'h01;
  localparam logic [7:0] SLC_MODE_RST = 8'h00;
  localparam logic [7:0] SLC_RESYNC_RST = 8'h01;
  localparam logic [7:0] SLC_CTRL_RST = 8'h03;
  localparam logic [7:0] SLC_PAT_RST = 8'h00;
  localparam logic [7:0] SLC_DID_RST = 8'h00;
  localparam logic [7:0] SLC_AUX_RST = 8'h00;
  // writable bits of each register
  localparam logic [7:0] SLC_ENABLE_MASK = 8'h01;
  localparam logic [7:0] SLC_MODE_MASK = 8'h3F;
  localparam logic [7:0] SLC_RESYNC_MASK = 8'h01;
  localparam logic [7:0] SLC_CTRL_MASK = 8'h1F;
  localparam logic [7:0] SLC_PAT_MASK = 8'h1F;
  localparam logic [7:0] SLC_AUX_MASK = 8'h01;
  // link control field positions
  localparam int SLC_CTRL_SCR = 0;
  localparam int SLC_CTRL_FMT = 1;
  localparam int SLC_CTRL_SRC = 2;
  localparam int SLC_CTRL_UPPER = 4;
  // status field positions
  localparam int SLC_STAT_RUN = 0;
  localparam int SLC_STAT_SYNC = 1;
  // resync source codes
  localparam logic [1:0] SLC_SRC_SE = 2'h0;
  localparam logic [1:0] SLC_SRC_TS = 2'h1;
  localparam logic [1:0] SLC_SRC_SOFT = 2'h2;
  // test pattern codes
  localparam logic [4:0] SLC_P_NORMAL = 5'h00;
  localparam logic [4:0] SLC_P_PRBS7 = 5'h01;
  localparam logic [4:0] SLC_P_PRBS15 = 5'h02;
  localparam logic [4:0] SLC_P_PRBS23 = 5'h03;
  localparam logic [4:0] SLC_P_RAMP = 5'h04;
  localparam logic [4:0] SLC_P_TRANSPORT = 5'h05;
  localparam logic [4:0] SLC_P_D21_5 = 5'h06;
  localparam logic [4:0] SLC_P_K28_5 = 5'h07;
  localparam logic [4:0] SLC_P_ILA = 5'h08;
  localparam logic [4:0] SLC_P_RPAT = 5'h09;
  localparam logic [4:0] SLC_P_LOW = 5'h0A;
  localparam logic [4:0] SLC_P_HIGH = 5'h0B;
  localparam logic [4:0] SLC_P_RSVD12 = 5'h0C;
  localparam logic [4:0] SLC_P_PRBS9 = 5'h0D;
  localparam logic [4:0] SLC_P_PRBS31 = 5'h0E;
  localparam logic [4:0] SLC_P_CLOCK = 5'h0F;
  localparam logic [4:0] SLC_P_K28_7 = 5'h10;
  // characters
  localparam logic [7:0] SLC_K28_0 = 8'h1C;
  localparam logic [7:0] SLC_K28_3 = 8'h7C;
  localparam logic [7:0] SLC_K28_4 = 8'h9C;
  localparam logic [7:0] SLC_K28_5 = 8'hBC;
  localparam logic [7:0] SLC_K28_7 = 8'hFC;
  localparam logic [7:0] SLC_D21_5 = 8'hB5;
  localparam logic [7:0] SLC_CLK_LO = 8'h00;
  localparam logic [7:0] SLC_CLK_HI = 8'hFF;
  localparam logic [7:0] SLC_TRANSPORT_XOR = 8'h5A;
  localparam logic [14:0] SLC_SCR_SEED = 15'h7FFF;
  localparam logic [30:0] SLC_LFSR_SEED = 31'h7FFFFFFF;
  // multiframe counter wraps after this position
  localparam logic [7:0] SLC_MF_LAST = 8'h1F;
  localparam logic [3:0] SLC_RPAT_LAST = 4'hB;
  // controller register offsets
  localparam logic [3:0] SLC_H_CFG = 4'h0;
  localparam logic [3:0] SLC_H_PAT = 4'h1;
  localparam logic [3:0] SLC_H_DID = 4'h2;
  localparam logic [3:0] SLC_H_MODE = 4'h3;
  localparam logic [3:0] SLC_H_GO = 4'h4;
  localparam logic [3:0] SLC_H_STAT = 4'h5;
  localparam logic [3:0] SLC_H_RESYNC = 4'h6;
  localparam logic [3:0] SLC_H_DEVSTAT = 4'h7;
  localparam logic [7:0] SLC_H_CFG_RST = 8'h03;
  localparam logic [7:0] SLC_H_ZERO = 8'h00;
endpackage

// ===== pkg/slc_link_if.sv
// register port, resync pins and lanes between controller and link device
`timescale 1ns/10ps
interface slc_link_if #(parameter int NLANES = slc_pkg::SLC_NLANES,
                        parameter int LW = slc_pkg::SLC_LW);
  logic [9:0] addr;
  logic [7:0] wdata;
  logic we;
  logic re;
  logic [7:0] rdata;
  logic se_pin;
  logic ts_p;
  logic ts_n;
  logic [NLANES*LW-1:0] lane_data;
  logic [NLANES-1:0] lane_k;
  logic [NLANES-1:0] lane_on;
  modport dev (input addr, wdata, we, re, se_pin, ts_p, ts_n,
               output rdata, lane_data, lane_k, lane_on);
  modport ctl (output addr, wdata, we, re, se_pin, ts_p, ts_n,
               input rdata, lane_data, lane_k, lane_on);
endinterface

// ===== core/slc_pattern_gen.sv
// test pattern source and multiframe position counter
`timescale 1ns/10ps
module slc_pattern_gen (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic run, // link enabled
  input wire logic [4:0] code, // pattern select
  input wire logic [7:0] link_device_identifier, // identifier for alignment sequence
  output logic [7:0] word, // pattern byte
  output logic kchar, // byte is a control character
  output logic [7:0] mf_pos // multiframe position
);
  import slc_pkg::*;

  typedef struct packed {
    logic [30:0] lfsr;
    logic [7:0] cnt;
    logic [3:0] ridx;
    logic ph;
    logic [7:0] word;
    logic k;
  } slc_pg_st_t;

  slc_pg_st_t q_ff;
  slc_pg_st_t nxt_q;

  // eight serial steps of a two-tap lfsr, returns {state, byte}
  function automatic logic [38:0] prbs8(input logic [30:0] s, input int n, input int m);
    logic [30:0] st;
    logic [7:0] o;
    logic fb;
    st = s;
    o = 8'h00;
    for (int i = 0; i < 8; i++) begin
      fb = st[n-1] ^ st[m-1];
      st = {st[29:0], fb};
      o = {o[6:0], fb};
    end
    return {st, o};
  endfunction

  // fixed twelve-symbol jitter pattern
  function automatic logic [7:0] rpat(input logic [3:0] i);
    case (i)
      4'h0: rpat = 8'hBE;
      4'h1: rpat = 8'hD7;
      4'h2: rpat = 8'hA1;
      4'h3: rpat = 8'h86;
      4'h4: rpat = 8'h1E;
      4'h5: rpat = 8'h1E;
      4'h6: rpat = 8'h4A;
      4'h7: rpat = 8'h33;
      4'h8: rpat = 8'hF0;
      4'h9: rpat = 8'h0F;
      4'hA: rpat = 8'h55;
      default: rpat = 8'hAA;
    endcase
  endfunction

  always_comb begin
    logic [38:0] pr;
    pr = 39'h0000000000;
    nxt_q = q_ff;
    if (!run) begin
      // counter held in reset while the link is off
      nxt_q.lfsr = SLC_LFSR_SEED;
      nxt_q.cnt = 8'h00;
      nxt_q.ridx = 4'h0;
      nxt_q.ph = 1'b0;
      nxt_q.word = 8'h00;
      nxt_q.k = 1'b0;
    end else begin
      nxt_q.cnt = (q_ff.cnt == SLC_MF_LAST) ? 8'h00 : q_ff.cnt + 8'h01;
      nxt_q.ridx = (q_ff.ridx == SLC_RPAT_LAST) ? 4'h0 : q_ff.ridx + 4'h1;
      nxt_q.ph = ~q_ff.ph;
      nxt_q.k = 1'b0;
      case (code)
        SLC_P_PRBS7: pr = prbs8(q_ff.lfsr, 7, 6);
        SLC_P_PRBS9: pr = prbs8(q_ff.lfsr, 9, 5);
        SLC_P_PRBS15: pr = prbs8(q_ff.lfsr, 15, 14);
        SLC_P_PRBS23: pr = prbs8(q_ff.lfsr, 23, 18);
        SLC_P_PRBS31: pr = prbs8(q_ff.lfsr, 31, 28);
        default: pr = {q_ff.lfsr, 8'h00};
      endcase
      nxt_q.lfsr = pr[38:8];
      case (code)
        SLC_P_PRBS7, SLC_P_PRBS9, SLC_P_PRBS15, SLC_P_PRBS23, SLC_P_PRBS31: begin
          nxt_q.word = pr[7:0];
        end
        SLC_P_RAMP: nxt_q.word = q_ff.cnt;
        SLC_P_TRANSPORT: nxt_q.word = q_ff.cnt ^ SLC_TRANSPORT_XOR;
        SLC_P_D21_5: nxt_q.word = SLC_D21_5;
        SLC_P_K28_5: begin
          nxt_q.word = SLC_K28_5;
          nxt_q.k = 1'b1;
        end
        SLC_P_K28_7: begin
          nxt_q.word = SLC_K28_7;
          nxt_q.k = 1'b1;
        end
        SLC_P_ILA: begin
          // start, config marker, identifier, data ramp, end marker
          nxt_q.k = 1'b1;
          if (q_ff.cnt == 8'h00) begin
            nxt_q.word = SLC_K28_0;
          end else if (q_ff.cnt == 8'h01) begin
            nxt_q.word = SLC_K28_4;
          end else if (q_ff.cnt == SLC_MF_LAST) begin
            nxt_q.word = SLC_K28_3;
          end else begin
            nxt_q.k = 1'b0;
            nxt_q.word = (q_ff.cnt == 8'h02) ? link_device_identifier : q_ff.cnt;
          end
        end
        SLC_P_RPAT: nxt_q.word = rpat(q_ff.ridx);
        SLC_P_LOW: nxt_q.word = SLC_CLK_LO;
        SLC_P_HIGH: nxt_q.word = SLC_CLK_HI;
        SLC_P_CLOCK: nxt_q.word = q_ff.ph ? SLC_CLK_HI : SLC_CLK_LO;
        default: nxt_q.word = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '{lfsr: SLC_LFSR_SEED, cnt: 8'h00, ridx: 4'h0, ph: 1'b0, word: 8'h00, k: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign word = q_ff.word;
  assign kchar = q_ff.k;
  assign mf_pos = q_ff.cnt;
endmodule

// ===== core/slc_link_dev.sv
// link device end: registers, resync source, lane mapping, coding and test data
//
// Function
// - normal map drives lanes zero to L-1
// - upper map drives lanes four to 4+L-1
// - upper map only when four lanes or fewer
// - source zero takes single-ended resync pin
// - source two uses only software resync bit
// - encoding bit: offset binary or two's complement
// - scrambler bit gates scrambling in 8b/10b
// - 64b/66b modes always scramble
// - keep 8b/10b scrambler enabled (the controller forwards a cleared scrambler bit unchanged)
// - change link control only while disabled
// - reserved fields written with defaults only
// - test codes zero to six select patterns
// - codes 7,8,9,16 give 8b/10b patterns
// - codes 10 and 11 hold lanes low/high
// - codes 13,14,15 give PRBS9, PRBS31, clock
// - change test code only while disabled
// - soft resync bit zero requests resync
// - link disabled holds everything in reset
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module slc_link_dev #(
  parameter int NLANES = slc_pkg::SLC_NLANES,
  parameter int LW = slc_pkg::SLC_LW
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  slc_link_if.dev lnk, // register port, resync pins, lanes
  input wire logic [NLANES*LW-1:0] sample_in, // one sample word per logical lane
  input wire logic [3:0] lane_count, // lanes used by current link mode
  input wire logic enc_64b66b, // link mode uses 64b/66b coding
  output logic serializer_on, // serializer power request
  output logic link_clk_run, // clock gate enable for link logic
  output logic resync_req, // resync requested, active high
  output logic [7:0] mf_pos // multiframe position
);
  import slc_pkg::*;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] mode;
    logic [7:0] resync;
    logic [7:0] ctrl;
    logic [7:0] pat;
    logic [7:0] link_device_identifier;
    logic [7:0] aux;
    logic [7:0] rdata;
    logic [2:0] se_s;
    logic [2:0] ts_s;
    logic se_f;
    logic ts_f;
    logic [NLANES-1:0][14:0] whitening_on;
    logic [NLANES-1:0][LW-1:0] ldata;
    logic [NLANES-1:0] lk;
    logic [NLANES-1:0] lon;
    logic run_d;
  } slc_dev_st_t;

  slc_dev_st_t q_ff;
  slc_dev_st_t nxt_q;
  logic [7:0] pg_word;
  logic pg_k;
  logic run;
  logic sync_n;

  // self-synchronous 1+x^14+x^15 scrambler over one byte, returns {state, byte}
  function automatic logic [22:0] scr8(input logic [14:0] s, input logic [7:0] d);
    logic [14:0] st;
    logic [7:0] o;
    logic b;
    st = s;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ st[14] ^ st[13];
      st = {st[13:0], b};
      o[i] = b;
    end
    return {st, o};
  endfunction

  assign run = q_ff.enable[0];

  slc_pattern_gen u_pg (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .code(q_ff.pat[4:0]),
    .link_device_identifier(q_ff.link_device_identifier),
    .word(pg_word),
    .kchar(pg_k),
    .mf_pos(mf_pos)
  );

  // software request always counts, even when a pin is selected
  always_comb begin
    logic sel;
    sel = 1'b1;
    unique case (q_ff.ctrl[SLC_CTRL_SRC +: 2])
      SLC_SRC_SE: sel = q_ff.se_f;
      SLC_SRC_TS: sel = q_ff.aux[0] ? q_ff.ts_f : 1'b1;
      SLC_SRC_SOFT: sel = 1'b1;
      default: sel = 1'b1;
    endcase
    sync_n = sel & q_ff.resync[0];
  end

  always_comb begin
    int li;
    logic act;
    logic upper;
    logic [LW-1:0] smp;
    logic [22:0] sr;
    li = 0;
    act = 1'b0;
    upper = q_ff.ctrl[SLC_CTRL_UPPER];
    smp = '0;
    sr = 23'h000000;
    nxt_q = q_ff;
    nxt_q.rdata = 8'h00;
    if (lnk.we) begin
      unique case (lnk.addr)
        SLC_A_ENABLE: nxt_q.enable = lnk.wdata & SLC_ENABLE_MASK;
        SLC_A_MODE: nxt_q.mode = lnk.wdata & SLC_MODE_MASK;
        SLC_A_RESYNC: nxt_q.resync = lnk.wdata & SLC_RESYNC_MASK;
        SLC_A_CTRL: nxt_q.ctrl = lnk.wdata & SLC_CTRL_MASK;
        SLC_A_PAT: nxt_q.pat = lnk.wdata & SLC_PAT_MASK;
        SLC_A_DID: nxt_q.link_device_identifier = lnk.wdata;
        SLC_A_AUX: nxt_q.aux = lnk.wdata & SLC_AUX_MASK;
        default: nxt_q.rdata = 8'h00;
      endcase
    end
    if (lnk.re) begin
      unique case (lnk.addr)
        SLC_A_ENABLE: nxt_q.rdata = q_ff.enable;
        SLC_A_MODE: nxt_q.rdata = q_ff.mode;
        SLC_A_RESYNC: nxt_q.rdata = q_ff.resync;
        SLC_A_CTRL: nxt_q.rdata = q_ff.ctrl;
        SLC_A_PAT: nxt_q.rdata = q_ff.pat;
        SLC_A_DID: nxt_q.rdata = q_ff.link_device_identifier;
        SLC_A_AUX: nxt_q.rdata = q_ff.aux;
        SLC_A_STAT: begin
          nxt_q.rdata[SLC_STAT_RUN] = run;
          nxt_q.rdata[SLC_STAT_SYNC] = sync_n;
        end
        default: nxt_q.rdata = 8'h00;
      endcase
    end
    // pins pass three flops; a level counts once the last two agree
    nxt_q.se_s = {q_ff.se_s[1:0], lnk.se_pin};
    nxt_q.ts_s = {q_ff.ts_s[1:0], lnk.ts_p & ~lnk.ts_n};
    if (q_ff.se_s[2] == q_ff.se_s[1]) begin
      nxt_q.se_f = q_ff.se_s[2];
    end
    if (q_ff.ts_s[2] == q_ff.ts_s[1]) begin
      nxt_q.ts_f = q_ff.ts_s[2];
    end
    // lanes wait one cycle after enable so the pattern word is already valid
    nxt_q.run_d = run;
    for (int i = 0; i < NLANES; i++) begin
      if (upper) begin
        li = (i >= SLC_UPPER_BASE) ? i - SLC_UPPER_BASE : 0;
        act = (i >= SLC_UPPER_BASE) && (li < int'(lane_count));
      end else begin
        li = i;
        act = i < int'(lane_count);
      end
      smp = sample_in[li*LW +: LW];
      smp[LW-1] = smp[LW-1] ^ ~q_ff.ctrl[SLC_CTRL_FMT];
      if (!run || !q_ff.run_d || !act) begin
        // off lanes and a disabled link restart the scrambler too
        nxt_q.whitening_on[i] = SLC_SCR_SEED;
        nxt_q.ldata[i] = '0;
        nxt_q.lk[i] = 1'b0;
        nxt_q.lon[i] = 1'b0;
      end else begin
        nxt_q.lon[i] = 1'b1;
        if (q_ff.pat[4:0] != SLC_P_NORMAL) begin
          nxt_q.ldata[i] = pg_word;
          nxt_q.lk[i] = pg_k;
        end else if (!sync_n && !enc_64b66b) begin
          nxt_q.ldata[i] = SLC_K28_5;
          nxt_q.lk[i] = 1'b1;
        end else if (enc_64b66b || q_ff.ctrl[SLC_CTRL_SCR]) begin
          sr = scr8(q_ff.whitening_on[i], smp);
          nxt_q.whitening_on[i] = sr[22:8];
          nxt_q.ldata[i] = sr[7:0];
          nxt_q.lk[i] = 1'b0;
        end else begin
          nxt_q.ldata[i] = smp;
          nxt_q.lk[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '{enable: SLC_ENABLE_RST, mode: SLC_MODE_RST, resync: SLC_RESYNC_RST,
                ctrl: SLC_CTRL_RST, pat: SLC_PAT_RST, link_device_identifier: SLC_DID_RST, aux: SLC_AUX_RST,
                rdata: 8'h00, se_s: 3'h7, ts_s: 3'h7, se_f: 1'b1, ts_f: 1'b1,
                whitening_on: {NLANES{SLC_SCR_SEED}}, ldata: '0, lk: '0, lon: '0, run_d: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign lnk.rdata = q_ff.rdata;
  assign lnk.lane_data = q_ff.ldata;
  assign lnk.lane_k = q_ff.lk;
  assign lnk.lane_on = q_ff.lon;
  assign serializer_on = run;
  assign link_clk_run = run;
  assign resync_req = ~sync_n;
endmodule

// ===== core/slc_link_ctl.sv
// controller end: takes settings from software and applies them with the link disabled
`timescale 1ns/10ps
module slc_link_ctl (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  slc_link_if.ctl lnk, // register port, resync pins, lanes
  input wire logic [3:0] u_addr, // controller register offset
  input wire logic [7:0] u_wdata, // write data
  input wire logic u_we, // write strobe
  input wire logic u_re, // read strobe
  output logic [7:0] u_rdata, // read data, cycle after the strobe
  input wire logic rx_sync_n, // receiver resync pin, active low
  input wire logic [3:0] lane_count // lanes of the chosen link mode
);
  import slc_pkg::*;

  typedef enum logic [3:0] {
    SLC_S_IDLE, SLC_S_DIS, SLC_S_MODE, SLC_S_CTRL, SLC_S_PAT, SLC_S_DID, SLC_S_AUX, SLC_S_ENA
  } slc_ctl_state_t;

  typedef struct packed {
    slc_ctl_state_t st;
    logic [7:0] cfg;
    logic [7:0] pat;
    logic [7:0] link_device_identifier;
    logic [7:0] mode;
    logic en_after;
    logic refused;
    logic [7:0] devstat;
    logic re_d;
    logic [7:0] urd;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic [2:0] sy_s;
    logic sy_f;
  } slc_ctl_st_t;

  slc_ctl_st_t q_ff;
  slc_ctl_st_t nxt_q;

  function automatic logic pat_reserved(input logic [4:0] c);
    return (c == SLC_P_RSVD12) || (c > SLC_P_K28_7);
  endfunction

  always_comb begin
    logic busy;
    busy = q_ff.st != SLC_S_IDLE;
    nxt_q = q_ff;
    nxt_q.we = 1'b0;
    nxt_q.re = 1'b0;
    nxt_q.urd = 8'h00;
    nxt_q.re_d = q_ff.re;
    if (q_ff.re_d) begin
      nxt_q.devstat = lnk.rdata;
    end
    nxt_q.sy_s = {q_ff.sy_s[1:0], rx_sync_n};
    if (q_ff.sy_s[2] == q_ff.sy_s[1]) begin
      nxt_q.sy_f = q_ff.sy_s[2];
    end
    if (u_re) begin
      unique case (u_addr)
        SLC_H_CFG: nxt_q.urd = q_ff.cfg;
        SLC_H_PAT: nxt_q.urd = q_ff.pat;
        SLC_H_DID: nxt_q.urd = q_ff.link_device_identifier;
        SLC_H_MODE: nxt_q.urd = q_ff.mode;
        SLC_H_STAT: nxt_q.urd = {6'h00, q_ff.refused, busy};
        SLC_H_DEVSTAT: nxt_q.urd = q_ff.devstat;
        default: nxt_q.urd = 8'h00;
      endcase
    end
    // settings are frozen while a sequence runs
    if (u_we && !busy) begin
      unique case (u_addr)
        SLC_H_CFG: nxt_q.cfg = u_wdata & SLC_CTRL_MASK;
        SLC_H_PAT: nxt_q.pat = u_wdata & SLC_PAT_MASK;
        SLC_H_DID: nxt_q.link_device_identifier = u_wdata;
        SLC_H_MODE: nxt_q.mode = u_wdata & SLC_MODE_MASK;
        SLC_H_STAT: nxt_q.refused = q_ff.refused & ~u_wdata[1];
        SLC_H_GO: begin
          nxt_q.en_after = u_wdata[0];
          nxt_q.st = SLC_S_DIS;
          if (q_ff.cfg[SLC_CTRL_UPPER] && lane_count > SLC_UPPER_MAX_LANES) begin
            nxt_q.cfg[SLC_CTRL_UPPER] = 1'b0;
            nxt_q.refused = 1'b1;
          end
          if (pat_reserved(q_ff.pat[4:0])) begin
            nxt_q.pat = SLC_H_ZERO;
            nxt_q.refused = 1'b1;
          end
        end
        SLC_H_RESYNC: begin
          nxt_q.we = 1'b1;
          nxt_q.addr = SLC_A_RESYNC;
          nxt_q.wdata = u_wdata & SLC_RESYNC_MASK;
        end
        default: nxt_q.st = q_ff.st;
      endcase
    end
    unique case (q_ff.st)
      SLC_S_IDLE: begin
        // poll device status whenever no write goes out
        if (!nxt_q.we) begin
          nxt_q.re = 1'b1;
          nxt_q.addr = SLC_A_STAT;
        end
      end
      SLC_S_DIS: begin
        nxt_q.we = 1'b1;
        nxt_q.addr = SLC_A_ENABLE;
        nxt_q.wdata = SLC_H_ZERO;
        nxt_q.st = SLC_S_MODE;
      end
      SLC_S_MODE: begin
        nxt_q.we = 1'b1;
        nxt_q.addr = SLC_A_MODE;
        nxt_q.wdata = q_ff.mode;
        nxt_q.st = SLC_S_CTRL;
      end
      SLC_S_CTRL: begin
        nxt_q.we = 1'b1;
        nxt_q.addr = SLC_A_CTRL;
        nxt_q.wdata = q_ff.cfg;
        nxt_q.st = SLC_S_PAT;
      end
      SLC_S_PAT: begin
        nxt_q.we = 1'b1;
        nxt_q.addr = SLC_A_PAT;
        nxt_q.wdata = q_ff.pat;
        nxt_q.st = SLC_S_DID;
      end
      SLC_S_DID: begin
        nxt_q.we = 1'b1;
        nxt_q.addr = SLC_A_DID;
        nxt_q.wdata = q_ff.link_device_identifier;
        nxt_q.st = SLC_S_AUX;
      end
      SLC_S_AUX: begin
        nxt_q.we = 1'b1;
        nxt_q.addr = SLC_A_AUX;
        nxt_q.wdata = {7'h00, q_ff.cfg[SLC_CTRL_SRC +: 2] == SLC_SRC_TS};
        nxt_q.st = SLC_S_ENA;
      end
      SLC_S_ENA: begin
        nxt_q.we = 1'b1;
        nxt_q.addr = SLC_A_ENABLE;
        nxt_q.wdata = {7'h00, q_ff.en_after};
        nxt_q.st = SLC_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '{st: SLC_S_IDLE, cfg: SLC_H_CFG_RST, pat: SLC_H_ZERO, link_device_identifier: SLC_H_ZERO,
                mode: SLC_H_ZERO, en_after: 1'b0, refused: 1'b0, devstat: SLC_H_ZERO,
                re_d: 1'b0, urd: SLC_H_ZERO, addr: 10'h000, wdata: SLC_H_ZERO,
                we: 1'b0, re: 1'b0, sy_s: 3'h7, sy_f: 1'b1};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign u_rdata = q_ff.urd;
  assign lnk.addr = q_ff.addr;
  assign lnk.wdata = q_ff.wdata;
  assign lnk.we = q_ff.we;
  assign lnk.re = q_ff.re;
  assign lnk.se_pin = q_ff.sy_f;
  assign lnk.ts_p = q_ff.sy_f;
  assign lnk.ts_n = ~q_ff.sy_f;
endmodule

// ===== tb/slc_link_sva.sv
// link checker beside the interface
`timescale 1ns/10ps
module slc_link_sva (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [9:0] addr, // address
  input wire logic [7:0] wdata, // data
  input wire logic we, // write
  input wire logic [63:0] lane_data, // bytes
  input wire logic [7:0] lane_k, // flags
  input wire logic [7:0] lane_on // active
);
  import slc_pkg::*;
  logic en_ff;
  logic [4:0] pat_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // bus view only: device registers are not visible here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= 1'b1;
      pat_ff <= 5'h00;
    end else if (we && addr == SLC_A_ENABLE) begin
      en_ff <= wdata[0];
    end else if (we && addr == SLC_A_PAT) begin
      pat_ff <= wdata[4:0];
    end
  end
  property p_off;
    we && addr == SLC_A_ENABLE && !wdata[0] |-> ##3 (!lane_on && !lane_data)[*4];
  endproperty
  a_off: assert property (p_off) else $error("lanes left on");
  property p_map;
    |lane_on |-> !(lane_on & (lane_on + 8'h01)) || !(lane_on & (lane_on + 8'h10));
  endproperty
  a_map: assert property (p_map) else $error("lane gap");
  property p_ctl;
    we && addr == SLC_A_CTRL |-> !en_ff;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control while on");
  property p_pat;
    we && addr == SLC_A_PAT |-> !en_ff;
  endproperty
  a_pat: assert property (p_pat) else $error("pattern while on");
  property p_code;
    we && addr == SLC_A_PAT |-> wdata <= 8'h10 && wdata != 8'h0C;
  endproperty
  a_code: assert property (p_code) else $error("reserved code");
  property p_high;
    lane_on[0] && pat_ff == SLC_P_HIGH |-> lane_data[7:0] == 8'hFF;
  endproperty
  a_high: assert property (p_high) else $error("lane not high");
  property p_k28;
    lane_on[0] && pat_ff == SLC_P_K28_5 |-> lane_k[0] && lane_data[7:0] == SLC_K28_5;
  endproperty
  a_k28: assert property (p_k28) else $error("bad comma");
  property p_ramp;
    lane_on[0] && $past(lane_on[0]) && pat_ff == SLC_P_RAMP |-> lane_data[7:0] ==
      ($past(lane_data[7:0]) == SLC_MF_LAST ? 8'h00 : $past(lane_data[7:0]) + 8'h01);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step");
endmodule

// ===== tb/serial_link_output_control_tb_top.sv
// bench joining controller and device ends
`timescale 1ns/10ps
module serial_link_output_control_tb_top;
  import slc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, u_we = 1'b0, u_re = 1'b0, rx_sync_n = 1'b1;
  logic enc_64b66b = 1'b0, serializer_on, resync_req, link_clk_run;
  logic [3:0] u_addr = 4'h0, lane_count = 4'h4;
  logic [7:0] u_wdata = 8'h00, u_rdata, mf_pos;
  logic [63:0] sample_in = 64'h8877665544332211;
  int err_total = 0, total_checks = 0;
  slc_link_if lnk ();
  slc_link_ctl slc_link_ctl_i (.clk, .rst_n, .lnk, .u_addr, .u_wdata, .u_we, .u_re, .u_rdata,
    .rx_sync_n, .lane_count);
  slc_link_dev slc_link_dev_i (.clk, .rst_n, .lnk, .sample_in, .lane_count, .enc_64b66b,
    .serializer_on, .link_clk_run, .resync_req, .mf_pos);
  slc_link_sva slc_link_sva_i (.clk, .rst_n, .addr(lnk.addr), .wdata(lnk.wdata), .we(lnk.we),
    .lane_data(lnk.lane_data), .lane_k(lnk.lane_k), .lane_on(lnk.lane_on));
  task automatic chk(input logic [63:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    u_addr <= a;
    u_wdata <= d;
    u_we <= 1'b1;
    @(posedge clk);
    u_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    u_addr <= a;
    u_re <= 1'b1;
    @(posedge clk);
    u_re <= 1'b0;
    #1 chk(u_rdata, e);
  endtask
  // busy lasts 7 cycles, lanes settle a few later
  task automatic go(input logic [7:0] cfg, input logic [4:0] pat);
    wr(SLC_H_CFG, cfg);
    wr(SLC_H_PAT, {3'h0, pat});
    wr(SLC_H_GO, 8'h01);
    repeat (14) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #30000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(SLC_H_CFG, SLC_H_CFG_RST);
    rd(4'hA, 8'h00);
    go(8'h02, SLC_P_HIGH);
    chk(lnk.lane_data, 64'hFFFFFFFF);
    go(8'h12, SLC_P_LOW);
    chk(lnk.lane_on, 8'hF0);
    @(posedge clk) lane_count <= 4'h5;
    go(8'h12, SLC_P_RSVD12);
    rd(SLC_H_CFG, 8'h02);
    rd(SLC_H_PAT, 8'h00);
    chk(lnk.lane_data[39:0], sample_in[39:0]);
    go(8'h00, SLC_P_NORMAL);
    chk(lnk.lane_data[39:0], sample_in[39:0] ^ {5{8'h80}});
    @(posedge clk) rx_sync_n <= 1'b0;
    go(8'h02, SLC_P_NORMAL);
    chk(lnk.lane_data[7:0], SLC_K28_5);
    go(8'h06, SLC_P_NORMAL);
    chk(lnk.lane_data[7:0], SLC_K28_5);
    go(8'h0A, SLC_P_NORMAL);
    chk(resync_req, 1'b0);
    wr(SLC_H_RESYNC, 8'h00);
    repeat (6) @(posedge clk);
    #1 chk(resync_req, 1'b1);
    wr(SLC_H_RESYNC, 8'h01);
    @(posedge clk) rx_sync_n <= 1'b1;
    go(8'h03, SLC_P_NORMAL);
    chk(lnk.lane_data[7:0] == sample_in[7:0], 1'b0);
    @(posedge clk) enc_64b66b <= 1'b1;
    go(8'h02, SLC_P_NORMAL);
    chk(lnk.lane_data[7:0] == sample_in[7:0], 1'b0);
    @(posedge clk) enc_64b66b <= 1'b0;
    for (int c = 1; c < 17; c++) begin
      go(8'h02, 5'(c));
      chk(lnk.lane_on, 8'h1F);
    end
    wr(SLC_H_GO, 8'h00);
    repeat (12) @(posedge clk);
    #1 chk(serializer_on, 1'b0);
    chk({link_clk_run, mf_pos}, 9'h000);
    print_verdict();
  end
endmodule
